// >>> hdl/key_sync.v
`timescale 1ns/1ps
`include "keypad_editor_regs.vh"

// ----------------------------------------
// Key synchroniser and press detector
// ----------------------------------------
module key_sync (
  input wire clk,
  input wire rst,
  input wire [4:0] key_raw,
  output reg [4:0] level,
  output wire [4:0] press
);
  reg [4:0] s1;
  reg [4:0] s2;
  reg [4:0] s3;
  reg [4:0] prev;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1 <= 5'h00;
      s2 <= 5'h00;
      s3 <= 5'h00;
      level <= 5'h00;
      prev <= 5'h00;
    end
    else
    begin
      s1 <= key_raw;
      s2 <= s1;
      s3 <= s2;
      prev <= level;
      // A change counts once stages two and three agree
      level <= (s2 & s3) | (level & (s2 | s3));
    end
  end

  assign press = level & ~prev;
endmodule

// >>> hdl/keypad_editor_regs.vh
`ifndef KEYPAD_EDITOR_REGS_VH
`define KEYPAD_EDITOR_REGS_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ 10000000
`define HOLD_TIME_S 5
`define HOLD_CYCLES (`HOLD_TIME_S * `CLK_HZ)
`define START_TIME_MS 200
`define START_CYCLES (`START_TIME_MS * (`CLK_HZ / 1000))
`define BLINK_CYCLES 2500000
`define BAR_SEGMENTS 5

// ----------------------------------------
// Widths
// ----------------------------------------
`define PNUM_W 8
`define PVAL_W 16
`define SEL_W 4
`define DIGITS 4

// ----------------------------------------
// Display codes
// ----------------------------------------
`define DISP_DEFAULT 4'h0
`define DISP_MONITOR 4'h1
`define DISP_PNUM 4'h2
`define DISP_PVAL 4'h3
`define DISP_WR_ENTRY 4'h4
`define DISP_WR_MODE 4'h5
`define DISP_BAR 4'h6
`define DISP_START 4'h7
`define DISP_FINISH 4'h8
`define DISP_RESET 4'h9
`define DISP_ERROR 4'ha

`endif

// >>> hdl/keypad_parameter_editor.v
`timescale 1ns/1ps
`include "keypad_editor_regs.vh"

module keypad_parameter_editor #(
  parameter HOLD_CYCLES = `HOLD_CYCLES,
  parameter START_CYCLES = `START_CYCLES,
  parameter BLINK_CYCLES = `BLINK_CYCLES
) (
  input wire CLK_SYS,
  input wire SYS_RST,
  input wire KEY_DATA,
  input wire KEY_MODE,
  input wire KEY_SHIFT,
  input wire KEY_INC,
  input wire KEY_DEC,
  input wire [`SEL_W-1:0] POWER_ON_DISPLAY_SELECT,
  input wire [`PVAL_W-1:0] PARAM_RD_VALUE,
  input wire PARAM_NEEDS_POWER_CYCLE,
  input wire NVM_DONE,
  input wire NVM_FAIL,
  output reg [`SEL_W-1:0] DISP_CODE,
  output reg [`SEL_W-1:0] MONITOR_ITEM,
  output reg [`PNUM_W-1:0] PARAM_NUM,
  output reg [`PVAL_W-1:0] PARAM_EDIT_VALUE,
  output reg [1:0] ACTIVE_DIGIT,
  output reg DIGIT_POINT_ON,
  output reg [2:0] BAR_LEVEL,
  output reg PARAM_WR_STB,
  output reg NVM_WRITE_START,
  output reg POWER_CYCLE_PENDING
);
  localparam ST_DEFAULT = 4'h0;
  localparam ST_MONITOR = 4'h1;
  localparam ST_PNUM = 4'h2;
  localparam ST_PVAL = 4'h3;
  localparam ST_WR_ENTRY = 4'h4;
  localparam ST_WR_MODE = 4'h5;
  localparam ST_HOLD = 4'h6;
  localparam ST_START = 4'h7;
  localparam ST_WAIT = 4'h8;
  localparam ST_FINISH = 4'h9;
  localparam ST_RESET = 4'ha;
  localparam ST_ERROR = 4'hb;

  wire [4:0] level;
  wire [4:0] press;
  wire data_p = press[0];
  wire mode_p = press[1];
  wire shift_p = press[2];
  wire inc_p = press[3];
  wire dec_p = press[4];
  wire inc_held = level[3];

  reg [3:0] state;
  reg [31:0] timer;
  reg [31:0] blink_cnt;
  reg blink;
  reg strap_taken;
  reg [`PVAL_W-1:0] step;
  wire [31:0] next_bar = timer * `BAR_SEGMENTS / HOLD_CYCLES + 32'h00000001;

  key_sync u_keys (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .key_raw({KEY_DEC, KEY_INC, KEY_SHIFT, KEY_MODE, KEY_DATA}),
    .level(level),
    .press(press)
  );

  // Step for the active digit (hex digits)
  always @*
  begin
    step = {{(`PVAL_W-1){1'b0}}, 1'b1} << {ACTIVE_DIGIT, 2'b00};
  end

  // ----------------------------------------
  // Flashing decimal point
  // ----------------------------------------
  always @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      blink_cnt <= 32'h00000000;
      blink <= 1'b0;
    end
    else if (blink_cnt >= BLINK_CYCLES - 1)
    begin
      blink_cnt <= 32'h00000000;
      blink <= ~blink;
    end
    else
    begin
      blink_cnt <= blink_cnt + 32'h00000001;
    end
  end

  always @*
  begin
    DIGIT_POINT_ON = ((state == ST_PNUM) || (state == ST_PVAL)) & blink;
  end

  // ----------------------------------------
  // Mode sequencer
  // ----------------------------------------
  always @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      state <= ST_DEFAULT;
      timer <= 32'h00000000;
      strap_taken <= 1'b0;
      MONITOR_ITEM <= 4'h0;
      DISP_CODE <= `DISP_DEFAULT;
      PARAM_NUM <= 8'h00;
      PARAM_EDIT_VALUE <= 16'h0000;
      ACTIVE_DIGIT <= 2'h0;
      BAR_LEVEL <= 3'h0;
      PARAM_WR_STB <= 1'b0;
      NVM_WRITE_START <= 1'b0;
      POWER_CYCLE_PENDING <= 1'b0;
    end
    else
    begin
      PARAM_WR_STB <= 1'b0;
      NVM_WRITE_START <= 1'b0;
      if (!strap_taken)
      begin
        // Strap caught after reset release, never inside the reset branch
        strap_taken <= 1'b1;
        MONITOR_ITEM <= POWER_ON_DISPLAY_SELECT;
      end
      case (state)
        ST_DEFAULT:
        begin
          DISP_CODE <= `DISP_DEFAULT;
          if (data_p)
          begin
            state <= ST_MONITOR;
            DISP_CODE <= `DISP_MONITOR;
          end
        end
        ST_MONITOR:
        begin
          if (mode_p)
          begin
            state <= ST_PNUM;
            DISP_CODE <= `DISP_PNUM;
            ACTIVE_DIGIT <= 2'h0;
          end
        end
        ST_PNUM:
        begin
          if (shift_p)
            ACTIVE_DIGIT <= (ACTIVE_DIGIT == 2'h1) ? 2'h0 : 2'h1;
          else if (inc_p)
            PARAM_NUM <= PARAM_NUM + step[`PNUM_W-1:0];
          else if (dec_p)
            PARAM_NUM <= PARAM_NUM - step[`PNUM_W-1:0];
          else if (data_p)
          begin
            PARAM_EDIT_VALUE <= PARAM_RD_VALUE;
            state <= ST_PVAL;
            DISP_CODE <= `DISP_PVAL;
            ACTIVE_DIGIT <= 2'h0;
          end
        end
        ST_PVAL:
        begin
          if (shift_p)
            ACTIVE_DIGIT <= ACTIVE_DIGIT + 2'h1;
          else if (inc_p)
            PARAM_EDIT_VALUE <= PARAM_EDIT_VALUE + step;
          else if (dec_p)
            PARAM_EDIT_VALUE <= PARAM_EDIT_VALUE - step;
          else if (data_p)
            PARAM_WR_STB <= 1'b1;
          else if (mode_p)
          begin
            state <= ST_WR_ENTRY;
            DISP_CODE <= `DISP_WR_ENTRY;
          end
        end
        ST_WR_ENTRY:
        begin
          if (data_p)
          begin
            state <= ST_WR_MODE;
            DISP_CODE <= `DISP_WR_MODE;
          end
        end
        ST_WR_MODE:
        begin
          BAR_LEVEL <= 3'h0;
          if (data_p)
          begin
            state <= ST_WR_ENTRY;
            DISP_CODE <= `DISP_WR_ENTRY;
          end
          else if (inc_p)
          begin
            state <= ST_HOLD;
            DISP_CODE <= `DISP_BAR;
            timer <= 32'h00000000;
          end
        end
        ST_HOLD:
        begin
          if (!inc_held)
          begin
            // Early release: nothing reaches memory
            state <= ST_WR_MODE;
            DISP_CODE <= `DISP_WR_MODE;
            BAR_LEVEL <= 3'h0;
          end
          else if (timer >= HOLD_CYCLES - 1)
          begin
            state <= ST_START;
            DISP_CODE <= `DISP_START;
            NVM_WRITE_START <= 1'b1;
            timer <= 32'h00000000;
          end
          else
          begin
            timer <= timer + 32'h00000001;
            BAR_LEVEL <= next_bar[2:0];
          end
        end
        ST_START:
        begin
          // Start indication lasts a short fixed time; a memory answer arriving during it is ignored
          if (timer >= START_CYCLES - 1)
            state <= ST_WAIT;
          else
            timer <= timer + 32'h00000001;
        end
        ST_WAIT:
        begin
          if (NVM_FAIL)
          begin
            state <= ST_ERROR;
            DISP_CODE <= `DISP_ERROR;
          end
          else if (NVM_DONE && PARAM_NEEDS_POWER_CYCLE)
          begin
            state <= ST_RESET;
            DISP_CODE <= `DISP_RESET;
            POWER_CYCLE_PENDING <= 1'b1;
          end
          else if (NVM_DONE)
          begin
            state <= ST_FINISH;
            DISP_CODE <= `DISP_FINISH;
          end
        end
        ST_FINISH, ST_RESET, ST_ERROR:
        begin
          // Outcome stays until Data; after an error the operator writes again
          if (data_p)
          begin
            state <= ST_WR_ENTRY;
            DISP_CODE <= `DISP_WR_ENTRY;
          end
        end
        default:
        begin
          state <= ST_DEFAULT;
          DISP_CODE <= `DISP_DEFAULT;
        end
      endcase
    end
  end
endmodule

// >>> verification/editor_checker.sv
`timescale 1ns/1ps
// ----------------------------------------
// Editor port checker
// ----------------------------------------
module editor_checker #(
  parameter HOLD_CYCLES = 40
) (
  input wire CLK_SYS,
  input wire SYS_RST,
  input wire KEY_INC,
  input wire [3:0] POWER_ON_DISPLAY_SELECT,
  input wire PARAM_NEEDS_POWER_CYCLE,
  input wire NVM_DONE,
  input wire NVM_FAIL,
  input wire [3:0] DISP_CODE,
  input wire [3:0] MONITOR_ITEM,
  input wire DIGIT_POINT_ON,
  input wire [2:0] BAR_LEVEL,
  input wire PARAM_WR_STB,
  input wire NVM_WRITE_START,
  input wire POWER_CYCLE_PENDING
);
  // Raw pin run length; clears on the cycle the pin drops, while the synced level still lags high
  reg [31:0] inc_run;
  always @(posedge CLK_SYS or posedge SYS_RST)
    if (SYS_RST)
      inc_run <= 32'h0;
    else
      inc_run <= KEY_INC ? inc_run + 32'h1 : 32'h0;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  property p_boot;
    $fell(SYS_RST) |=> MONITOR_ITEM == POWER_ON_DISPLAY_SELECT && DISP_CODE == 4'h0;
  endproperty
  a_boot: assert property (p_boot) else $error("power-on display wrong");
  property p_data;
    DISP_CODE != 4'h0 && $past(DISP_CODE) == 4'h0 |-> DISP_CODE == 4'h1;
  endproperty
  a_data: assert property (p_data) else $error("default display left wrongly");
  property p_mode;
    $past(DISP_CODE) == 4'h1 && DISP_CODE != 4'h1 |-> DISP_CODE == 4'h2;
  endproperty
  a_mode: assert property (p_mode) else $error("monitor mode left wrongly");
  property p_point;
    DIGIT_POINT_ON |-> DISP_CODE == 4'h2 || DISP_CODE == 4'h3;
  endproperty
  a_point: assert property (p_point) else $error("point flashes outside edit");
  property p_accept;
    PARAM_WR_STB |-> $past(DISP_CODE) == 4'h3 ##1 !PARAM_WR_STB;
  endproperty
  a_accept: assert property (p_accept) else $error("bad accept strobe");
  property p_hold;
    NVM_WRITE_START |-> inc_run >= HOLD_CYCLES && DISP_CODE == 4'h7 ##1 !NVM_WRITE_START;
  endproperty
  a_hold: assert property (p_hold) else $error("write started early");
  property p_bar;
    DISP_CODE == 4'h6 [*2] |-> BAR_LEVEL != 3'h0 && BAR_LEVEL <= 3'h5;
  endproperty
  a_bar: assert property (p_bar) else $error("bar level out of range");
  property p_finish;
    $rose(DISP_CODE == 4'h8) |-> $past(NVM_DONE) && !$past(NVM_FAIL)
      && !$past(PARAM_NEEDS_POWER_CYCLE);
  endproperty
  a_finish: assert property (p_finish) else $error("finish without success");
  property p_restart;
    $rose(DISP_CODE == 4'h9) |-> $past(NVM_DONE) && $past(PARAM_NEEDS_POWER_CYCLE)
      && POWER_CYCLE_PENDING;
  endproperty
  a_restart: assert property (p_restart) else $error("reset indication wrong");
  property p_error;
    $rose(DISP_CODE == 4'ha) |-> $past(NVM_FAIL);
  endproperty
  a_error: assert property (p_error) else $error("error without failure");
endmodule

bind keypad_parameter_editor editor_checker #(.HOLD_CYCLES(HOLD_CYCLES)) u_chk (
  .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .KEY_INC(KEY_INC),
  .POWER_ON_DISPLAY_SELECT(POWER_ON_DISPLAY_SELECT),
  .PARAM_NEEDS_POWER_CYCLE(PARAM_NEEDS_POWER_CYCLE), .NVM_DONE(NVM_DONE),
  .NVM_FAIL(NVM_FAIL), .DISP_CODE(DISP_CODE), .MONITOR_ITEM(MONITOR_ITEM),
  .DIGIT_POINT_ON(DIGIT_POINT_ON), .BAR_LEVEL(BAR_LEVEL), .PARAM_WR_STB(PARAM_WR_STB),
  .NVM_WRITE_START(NVM_WRITE_START), .POWER_CYCLE_PENDING(POWER_CYCLE_PENDING));

// >>> verification/nvm_partner.sv
`timescale 1ns/1ps
// ----------------------------------------
// Parameter store behind the editor
// ----------------------------------------
module nvm_partner (
  input wire clk,
  input wire rst,
  input wire start,
  input wire [7:0] param_num,
  input wire [1:0] outcome,
  input wire [7:0] delay,
  output wire [15:0] rd_value,
  output reg done,
  output reg fail,
  output wire needs_pc
);
  reg [7:0] cnt;
  assign rd_value = {8'h5a, param_num};
  assign needs_pc = outcome == 2'h1;
  // One-cycle answer; lines drop back low so a stale result is never reread
  always @(posedge clk or posedge rst)
    if (rst)
    begin
      cnt <= 8'h00;
      done <= 1'b0;
      fail <= 1'b0;
    end
    else
    begin
      cnt <= start ? delay : (cnt != 8'h00 ? cnt - 8'h01 : 8'h00);
      done <= cnt == 8'h01 && outcome != 2'h2;
      fail <= cnt == 8'h01 && outcome == 2'h2;
    end
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [4:0] keys = 5'h00;
  reg [1:0] outcome = 2'h0;
  reg [7:0] delay = 8'h06;
  reg [3:0] strap = 4'h5;
  wire [15:0] rd;
  wire [15:0] val;
  wire done, fail, npc, stb, wstart, pend, pt;
  wire [3:0] disp, mon;
  wire [7:0] pnum;
  wire [1:0] dig;
  wire [2:0] bar;
  integer failures = 0;
  integer comparisons = 0;
  integer stbs = 0;
  integer starts = 0;
  integer i;
  always #50 clk = ~clk;
  // Outputs are unknown until the first reset edge, so count only out of reset
  always @(posedge clk)
  begin
    if (!rst)
    begin
      stbs <= stbs + stb;
      starts <= starts + wstart;
    end
  end
  keypad_parameter_editor #(.HOLD_CYCLES(40), .START_CYCLES(4), .BLINK_CYCLES(8)) DUT (
    .CLK_SYS(clk), .SYS_RST(rst), .KEY_DATA(keys[0]), .KEY_MODE(keys[1]),
    .KEY_SHIFT(keys[2]), .KEY_INC(keys[3]), .KEY_DEC(keys[4]),
    .POWER_ON_DISPLAY_SELECT(strap), .PARAM_RD_VALUE(rd), .PARAM_NEEDS_POWER_CYCLE(npc),
    .NVM_DONE(done), .NVM_FAIL(fail), .DISP_CODE(disp), .MONITOR_ITEM(mon),
    .PARAM_NUM(pnum), .PARAM_EDIT_VALUE(val), .ACTIVE_DIGIT(dig), .DIGIT_POINT_ON(pt),
    .BAR_LEVEL(bar), .PARAM_WR_STB(stb), .NVM_WRITE_START(wstart), .POWER_CYCLE_PENDING(pend));
  nvm_partner u_nvm (.clk(clk), .rst(rst), .start(wstart), .param_num(pnum),
    .outcome(outcome), .delay(delay), .rd_value(rd), .done(done), .fail(fail), .needs_pc(npc));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input [15:0] seen, input [15:0] exp);
  begin
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  end
  endtask
  // Long enough for the synchroniser to see both edges
  task press(input integer k);
  begin
    keys[k] = 1'b1;
    repeat (8) @(negedge clk);
    keys[k] = 1'b0;
    repeat (8) @(negedge clk);
  end
  endtask
  task close_out;
  begin
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_setting;
    reg hi, lo;
  begin
    hi = 1'b0;
    lo = 1'b0;
    press(0);
    chk(16'(disp), 16'h1);
    press(1);
    chk(16'(disp), 16'h2);
    press(3);
    press(2);
    chk(16'(dig), 16'h1);
    press(3);
    press(2);
    press(4);
    chk(16'(pnum), 16'h10);
    repeat (20)
    begin
      @(negedge clk);
      hi = hi | (pt === 1'b1);
      lo = lo | (pt === 1'b0);
    end
    chk(16'({hi, lo}), 16'h3);
    press(0);
    chk(16'(disp), 16'h3);
    chk(val, 16'h5a10);
    press(3);
    chk(val, 16'h5a11);
    press(2);
    press(3);
    chk(val, 16'h5a21);
    press(0);
    chk(16'(stbs), 16'h1);
    press(1);
    chk(16'(disp), 16'h4);
    press(0);
    chk(16'(disp), 16'h5);
  end
  endtask
  task t_abort;
  begin
    keys[3] = 1'b1;
    repeat (20) @(negedge clk);
    chk(16'(disp), 16'h6);
    keys[3] = 1'b0;
    repeat (8) @(negedge clk);
    chk(16'(disp), 16'h5);
    chk(16'(starts), 16'h0);
    press(0);
    chk(16'(disp), 16'h4);
    press(0);
  end
  endtask
  task t_write(input [1:0] oc, input [15:0] code);
  begin
    outcome = oc;
    keys[3] = 1'b1;
    i = 0;
    while (wstart !== 1'b1 && i < 200)
    begin
      @(negedge clk);
      i = i + 1;
    end
    @(negedge clk);
    chk(16'(i >= 40 && i < 50), 16'h1);
    chk(16'(disp), 16'h7);
    keys[3] = 1'b0;
    repeat (24) @(negedge clk);
    chk(16'(disp), code);
    press(0);
    press(0);
    chk(16'(disp), 16'h5);
  end
  endtask
  initial
  begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    chk(16'(disp), 16'h0);
    chk(16'(mon), 16'h5);
    t_setting;
    t_abort;
    t_write(2'h0, 16'h8);
    delay = 8'h0c;
    t_write(2'h1, 16'h9);
    chk(16'(pend), 16'h1);
    t_write(2'h2, 16'ha);
    t_write(2'h0, 16'h8);
    // Second power-up with another strap: new item shown, pending flag gone
    rst = 1'b1;
    strap = 4'h3;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    chk(16'(disp), 16'h0);
    chk(16'(mon), 16'h3);
    chk(16'(pend), 16'h0);
    close_out;
  end
  initial
  begin
    #1000000;
    failures = failures + 1;
    close_out;
  end
endmodule
